// ===== shared/tsc_pkg.sv
package tsc_pkg;

  // Clocking and time base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BASE_HZ = 1_000_000;
  localparam int unsigned TICK_DIV = CLK_HZ / BASE_HZ;
  localparam int TICK_W = 6;
  localparam int RATE_W = 3;
  localparam int DIV_W = 20;
  localparam logic [RATE_W-1:0] RATE_MAX = 3'h6;

  // Data path and memory geometry
  localparam int NUM_CH = 2;
  localparam int SMP_W = 16;
  localparam int VAL_W = SMP_W + 2;
  localparam int SEG_W = 2;
  localparam int SEG_LEN_W = 8;
  localparam int ADDR_W = SEG_W + SEG_LEN_W;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam int DLY_W = 16;

  // APB map, byte addresses
  localparam int PADDR_W = 13;
  localparam logic [PADDR_W-1:0] ADR_CTRL = 13'h0000;
  localparam logic [PADDR_W-1:0] ADR_CMD = 13'h0004;
  localparam logic [PADDR_W-1:0] ADR_DELAY = 13'h0008;
  localparam logic [PADDR_W-1:0] ADR_STATUS = 13'h000C;
  localparam logic [PADDR_W-1:0] ADR_TRIG_IDX = 13'h0010;
  localparam int CH_BLK_LSB = 5;
  localparam logic [PADDR_W-CH_BLK_LSB-1:0] CH_BLK = 8'h02;
  localparam int CH_SEL_BIT = 4;
  localparam logic [1:0] CH_REG_CFG = 2'h0;
  localparam logic [1:0] CH_REG_LVL = 2'h1;
  localparam logic [1:0] CH_REG_HYS = 2'h2;
  localparam int MEM_WIN_BIT = 12;

  // Field positions
  localparam int CTRL_PAUSE_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_SEG_LSB = 4;
  localparam int CTRL_RATE_LSB = 8;
  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_MAN_BIT = 2;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DIR_BIT = 2;
  localparam int CFG_SLOPE_BIT = 3;
  localparam int HI_LSB = 16;
  localparam int ST_TRIG_BIT = 4;
  localparam int ST_IDX_LSB = 8;
  localparam int ST_SEG_LSB = 16;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
  localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;

  typedef enum logic [1:0] {TSC_OFF, TSC_BASIC, TSC_DUAL} tsc_mode_t;

  typedef enum logic [1:0] {TSC_IDLE, TSC_ARMED, TSC_POST, TSC_DONE} tsc_state_t;

  typedef struct packed {
    tsc_mode_t mode;
    logic dir_neg;
    logic slope;
    logic [SMP_W-1:0] lvl_p;
    logic [SMP_W-1:0] lvl_s;
    logic [SMP_W-1:0] hys_p;
    logic [SMP_W-1:0] hys_s;
  } tsc_chan_cfg_t;

  localparam tsc_chan_cfg_t CFG_RST = '0;

endpackage

// ===== verilog/tsc_level_det.sv
`timescale 1ns/1ps
module tsc_level_det
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic smp_valid_in,
  input wire logic [SMP_W-1:0] smp_in,
  input wire tsc_chan_cfg_t cfg_in,
  input wire logic restart_in,
  output logic trig_out
);

  logic [SMP_W-1:0] prev_r;
  logic prev_ok_r;
  logic trig_r;
  logic signed [VAL_W-1:0] val;
  logic [1:0] fire;
  logic [1:0] arm_hit;
  logic [1:0] in_use;
  logic take;

  // Slope mode needs one earlier sample before a result is meaningful
  assign take = smp_valid_in & (~cfg_in.slope | prev_ok_r);

  always_comb
  begin
    if (cfg_in.slope)
    begin
      val = VAL_W'($signed(smp_in)) - VAL_W'($signed(prev_r));
    end
    else
    begin
      val = VAL_W'($signed(smp_in));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_r <= '0;
      prev_ok_r <= 1'b0;
    end
    else if (restart_in)
    begin
      prev_ok_r <= 1'b0;
    end
    else if (smp_valid_in)
    begin
      prev_r <= smp_in;
      prev_ok_r <= 1'b1;
    end
  end

  // Level 0 is primary, level 1 secondary with opposite direction
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_lvl
      logic armed_r;
      logic signed [VAL_W-1:0] lvl;
      logic signed [VAL_W-1:0] band;
      logic neg;
      assign lvl = VAL_W'($signed((g == 0) ? cfg_in.lvl_p : cfg_in.lvl_s));
      assign band = $signed({2'b00, (g == 0) ? cfg_in.hys_p : cfg_in.hys_s});
      assign neg = (g == 0) ? cfg_in.dir_neg : ~cfg_in.dir_neg;
      assign in_use[g] = (cfg_in.mode == TSC_BASIC && g == 0) || (cfg_in.mode == TSC_DUAL);
      // Strict compare: a sample equal to the level never fires
      assign fire[g] = armed_r & (neg ? (val < lvl) : (val > lvl));
      // Band sits below the level for rising, above it for falling
      assign arm_hit[g] = neg ? (val > lvl + band) : (val < lvl - band);

      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          armed_r <= 1'b0;
        end
        else if (restart_in || !in_use[g])
        begin
          armed_r <= 1'b0;
        end
        else if (take)
        begin
          if (fire[g])
          begin
            armed_r <= 1'b0;
          end
          else if (arm_hit[g])
          begin
            armed_r <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trig_r <= 1'b0;
    end
    else
    begin
      trig_r <= take & ~restart_in & |(fire & in_use);
    end
  end

  assign trig_out = trig_r;

endmodule // tsc_level_det

// ===== verilog/tsc_top.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module tsc_top
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic adc_strobe_out,
  input wire logic adc_valid_in,
  input wire logic [NUM_CH-1:0][SMP_W-1:0] adc_data_in,
  input wire logic ext_trig_in,
  output logic rec_trig_out,
  output logic sweep_done_out
);

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic pause_r;
  logic ext_en_r;
  logic [SEG_W-1:0] seg_sel_r;
  logic [RATE_W-1:0] rate_r;
  logic [DLY_W-1:0] delay_r;
  tsc_chan_cfg_t cfg_r [NUM_CH];
  logic run_cmd;
  logic stop_cmd;
  logic man_cmd;
  logic setup;
  logic wr_acc;

  tsc_state_t state_r;
  logic [SEG_W-1:0] seg_r;
  logic [SEG_LEN_W-1:0] wr_idx_r;
  logic [SEG_LEN_W-1:0] trig_idx_r;
  logic [DLY_W-1:0] dly_cnt_r;
  logic triggered_r;
  logic rec_trig_r;
  logic done_r;
  logic wr_en;
  logic trig_any;
  logic [NUM_CH-1:0] chan_trig;
  logic [NUM_CH*SMP_W-1:0] mem [MEM_DEPTH];

  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [DIV_W-1:0] dec_cnt_r;
  logic strobe_r;

  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_lvl_r;
  logic ext_edge_r;

  function automatic logic is_chan(input logic [PADDR_W-1:0] a);
    is_chan = (a[PADDR_W-1:CH_BLK_LSB] == CH_BLK) && (a[3:2] != 2'h3);
  endfunction

  function automatic logic is_mapped(input logic [PADDR_W-1:0] a);
    is_mapped = a[MEM_WIN_BIT] || is_chan(a) || a == ADR_CTRL || a == ADR_CMD ||
                a == ADR_DELAY || a == ADR_STATUS || a == ADR_TRIG_IDX;
  endfunction

  function automatic logic [DIV_W-1:0] decade_top(input logic [RATE_W-1:0] r);
    case (r)
      3'h0: decade_top = 20'h0_0000;
      3'h1: decade_top = 20'h0_0009;
      3'h2: decade_top = 20'h0_0063;
      3'h3: decade_top = 20'h0_03E7;
      3'h4: decade_top = 20'h0_270F;
      3'h5: decade_top = 20'h1_869F;
      default: decade_top = 20'hF_423F;
    endcase
  endfunction

  // APB: answer is ready in the cycle after setup, no wait states
  assign setup = psel_in & ~penable_in;
  assign wr_acc = psel_in & penable_in & pwrite_in & pready_r & ~pslverr_r;
  assign run_cmd = wr_acc && paddr_in == ADR_CMD && pwdata_in[CMD_RUN_BIT];
  assign stop_cmd = wr_acc && paddr_in == ADR_CMD && pwdata_in[CMD_STOP_BIT];
  assign man_cmd = wr_acc && paddr_in == ADR_CMD && pwdata_in[CMD_MAN_BIT];

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RD_ZERO;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & ~is_mapped(paddr_in);
      if (setup && !pwrite_in)
      begin
        prdata_r <= RD_ZERO;
        if (paddr_in[MEM_WIN_BIT])
        begin
          prdata_r <= 32'(mem[paddr_in[ADDR_W+1:2]]);
        end
        else if (is_chan(paddr_in))
        begin
          case (paddr_in[3:2])
            CH_REG_CFG: prdata_r <= 32'({cfg_r[paddr_in[CH_SEL_BIT]].slope,
                                         cfg_r[paddr_in[CH_SEL_BIT]].dir_neg,
                                         cfg_r[paddr_in[CH_SEL_BIT]].mode});
            CH_REG_LVL: prdata_r <= {cfg_r[paddr_in[CH_SEL_BIT]].lvl_s,
                                     cfg_r[paddr_in[CH_SEL_BIT]].lvl_p};
            default: prdata_r <= {cfg_r[paddr_in[CH_SEL_BIT]].hys_s,
                                  cfg_r[paddr_in[CH_SEL_BIT]].hys_p};
          endcase
        end
        else
        begin
          case (paddr_in)
            ADR_CTRL:
            begin
              prdata_r[CTRL_PAUSE_BIT] <= pause_r;
              prdata_r[CTRL_EXT_BIT] <= ext_en_r;
              prdata_r[CTRL_SEG_LSB +: SEG_W] <= seg_sel_r;
              prdata_r[CTRL_RATE_LSB +: RATE_W] <= rate_r;
            end
            ADR_DELAY: prdata_r <= 32'(delay_r);
            ADR_STATUS:
            begin
              prdata_r[1:0] <= state_r;
              prdata_r[ST_TRIG_BIT] <= triggered_r;
              prdata_r[ST_IDX_LSB +: SEG_LEN_W] <= wr_idx_r;
              prdata_r[ST_SEG_LSB +: SEG_W] <= seg_r;
            end
            ADR_TRIG_IDX: prdata_r <= 32'(trig_idx_r);
            default: prdata_r <= RD_ZERO;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pause_r <= 1'b0;
      ext_en_r <= 1'b0;
      seg_sel_r <= '0;
      rate_r <= '0;
      delay_r <= DLY_ZERO;
    end
    else if (wr_acc && paddr_in == ADR_CTRL)
    begin
      pause_r <= pwdata_in[CTRL_PAUSE_BIT];
      ext_en_r <= pwdata_in[CTRL_EXT_BIT];
      seg_sel_r <= pwdata_in[CTRL_SEG_LSB +: SEG_W];
      // Rates beyond the slowest decade are clamped rather than refused
      rate_r <= (pwdata_in[CTRL_RATE_LSB +: RATE_W] > RATE_MAX) ? RATE_MAX :
                pwdata_in[CTRL_RATE_LSB +: RATE_W];
    end
    else if (wr_acc && paddr_in == ADR_DELAY)
    begin
      delay_r <= pwdata_in[DLY_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        cfg_r[i] <= CFG_RST;
      end
    end
    else if (wr_acc && is_chan(paddr_in))
    begin
      case (paddr_in[3:2])
        CH_REG_CFG:
        begin
          cfg_r[paddr_in[CH_SEL_BIT]].mode <= tsc_mode_t'(pwdata_in[CFG_MODE_LSB +: 2]);
          cfg_r[paddr_in[CH_SEL_BIT]].dir_neg <= pwdata_in[CFG_DIR_BIT];
          cfg_r[paddr_in[CH_SEL_BIT]].slope <= pwdata_in[CFG_SLOPE_BIT];
        end
        CH_REG_LVL:
        begin
          cfg_r[paddr_in[CH_SEL_BIT]].lvl_p <= pwdata_in[SMP_W-1:0];
          cfg_r[paddr_in[CH_SEL_BIT]].lvl_s <= pwdata_in[HI_LSB +: SMP_W];
        end
        default:
        begin
          cfg_r[paddr_in[CH_SEL_BIT]].hys_p <= pwdata_in[SMP_W-1:0];
          cfg_r[paddr_in[CH_SEL_BIT]].hys_s <= pwdata_in[HI_LSB +: SMP_W];
        end
      endcase
    end
  end

  // Time base: 1 MHz tick, then a decade divider keeps rates base 10
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == TICK_W'(TICK_DIV - 1));
      tick_cnt_r <= (tick_cnt_r == TICK_W'(TICK_DIV - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dec_cnt_r <= '0;
      strobe_r <= 1'b0;
    end
    else
    begin
      strobe_r <= 1'b0;
      if (tick_r)
      begin
        if (dec_cnt_r >= decade_top(rate_r))
        begin
          dec_cnt_r <= '0;
          strobe_r <= 1'b1;
        end
        else
        begin
          dec_cnt_r <= dec_cnt_r + 1'b1;
        end
      end
    end
  end

  // External trigger pin: three stages, change taken when stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ext_lvl_r <= 1'b0;
      ext_edge_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_trig_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r)
      begin
        ext_lvl_r <= ext_s3_r;
      end
      ext_edge_r <= (ext_s2_r == ext_s3_r) & ext_s3_r & ~ext_lvl_r;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      tsc_level_det u_det (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .smp_valid_in(adc_valid_in),
        .smp_in(adc_data_in[c]),
        .cfg_in(cfg_r[c]),
        .restart_in(run_cmd),
        .trig_out(chan_trig[c])
      );
    end
  endgenerate

  assign trig_any = |chan_trig | man_cmd | (ext_en_r & ext_edge_r);
  assign wr_en = adc_valid_in & ~pause_r & (state_r == TSC_ARMED || state_r == TSC_POST);

  // Ring write: the index wraps inside the chosen segment
  always_ff @(posedge clk_in)
  begin
    if (wr_en)
    begin
      mem[{seg_r, wr_idx_r}] <= adc_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= TSC_IDLE;
      seg_r <= '0;
      wr_idx_r <= '0;
      trig_idx_r <= '0;
      dly_cnt_r <= DLY_ZERO;
      triggered_r <= 1'b0;
      rec_trig_r <= 1'b0;
    end
    else
    begin
      rec_trig_r <= 1'b0;
      if (wr_en)
      begin
        wr_idx_r <= wr_idx_r + 1'b1;
      end
      case (state_r)
        TSC_IDLE, TSC_DONE:
        begin
          if (run_cmd)
          begin
            state_r <= TSC_ARMED;
            seg_r <= seg_sel_r;
            wr_idx_r <= '0;
            triggered_r <= 1'b0;
          end
        end
        TSC_ARMED:
        begin
          if (stop_cmd)
          begin
            state_r <= TSC_IDLE;
          end
          else if (trig_any)
          begin
            // Trigger point is the sample written just before the pulse
            triggered_r <= 1'b1;
            rec_trig_r <= 1'b1;
            trig_idx_r <= wr_idx_r - 1'b1;
            dly_cnt_r <= delay_r;
            state_r <= (delay_r == DLY_ZERO) ? TSC_DONE : TSC_POST;
          end
        end
        TSC_POST:
        begin
          // Further triggers are ignored until the next run
          if (stop_cmd)
          begin
            state_r <= TSC_IDLE;
          end
          else if (wr_en)
          begin
            dly_cnt_r <= dly_cnt_r - 1'b1;
            if (dly_cnt_r == DLY_ONE)
            begin
              state_r <= TSC_DONE;
            end
          end
        end
        default: state_r <= TSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_r == TSC_DONE);
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign adc_strobe_out = strobe_r;
  assign rec_trig_out = rec_trig_r;
  assign sweep_done_out = done_r;

endmodule // tsc_top

// ===== sim/tsc_adc_model.sv
`timescale 1ns/1ps
module tsc_adc_model
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic strobe_in,
  input wire logic slow_in,
  input wire logic [NUM_CH-1:0][SMP_W-1:0] value_in,
  output logic valid_out,
  output logic [NUM_CH-1:0][SMP_W-1:0] data_out
);
  logic [3:0] pipe_r;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pipe_r <= '0;
    else
      pipe_r <= {pipe_r[2:0], strobe_in};
  end
  // Conversion takes one or four clocks; outside the valid cycle the bus shows garbage
  assign valid_out = slow_in ? pipe_r[3] : pipe_r[0];
  assign data_out = valid_out ? value_in : ~value_in;
endmodule // tsc_adc_model

// ===== sim/tsc_top_checker.sv
`timescale 1ns/1ps
module tsc_top_checker
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic adc_strobe_out,
  input wire logic adc_valid_in,
  input wire logic [NUM_CH-1:0][SMP_W-1:0] adc_data_in,
  input wire logic ext_trig_in,
  input wire logic rec_trig_out,
  input wire logic sweep_done_out
);
  logic [5:0] gap_r;
  logic seen_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Gap check assumes rate 0; the first strobe after reset has no reference
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end
    else
    begin
      gap_r <= adc_strobe_out ? 6'h00 : gap_r + 6'h01;
      seen_r <= seen_r | adc_strobe_out;
    end
  end
  setup_gives_ready_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  ready_needs_setup_a: assert property ($rose(pready_out) |-> $past(psel_in) && !$past(penable_in))
    else $error("pready without setup");
  err_with_ready_a: assert property (pslverr_out |-> pready_out && prdata_out == RD_ZERO)
    else $error("pslverr without pready or with data");
  strobe_gap_a: assert property (adc_strobe_out && seen_r |-> gap_r == 6'h31)
    else $error("strobe spacing wrong");
  trig_pulse_a: assert property (rec_trig_out |=> !rec_trig_out)
    else $error("recorder trigger longer than one cycle");
  trig_not_done_a: assert property (rec_trig_out |-> !sweep_done_out)
    else $error("trigger accepted after sweep end");
  done_holds_a: assert property (sweep_done_out && !$past(psel_in) |=> sweep_done_out)
    else $error("sweep end dropped without command");
  cover property (rec_trig_out);
  cover property (pslverr_out);
  cover property ($rose(sweep_done_out));
endmodule // tsc_top_checker

// ===== sim/trigger_sweep_capture_tb.sv
`timescale 1ns/1ps
bind tsc_top tsc_top_checker i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .adc_strobe_out(adc_strobe_out), .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in),
  .ext_trig_in(ext_trig_in), .rec_trig_out(rec_trig_out), .sweep_done_out(sweep_done_out));
module trigger_sweep_capture_tb
  import tsc_pkg::*;
;
  logic clk_in;
  logic rst_n_in;
  logic psel;
  logic penable;
  logic pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic strobe;
  logic valid;
  logic [NUM_CH-1:0][SMP_W-1:0] adc_data;
  logic [NUM_CH-1:0][SMP_W-1:0] smp_val;
  logic slow;
  logic ext_trig;
  logic rec_trig;
  logic done;
  int n_fail;
  int comparisons;
  int n_trig;
  tsc_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .adc_strobe_out(strobe), .adc_valid_in(valid),
    .adc_data_in(adc_data), .ext_trig_in(ext_trig), .rec_trig_out(rec_trig),
    .sweep_done_out(done));
  tsc_adc_model i_adc (.clk_in(clk_in), .rst_n_in(rst_n_in), .strobe_in(strobe),
    .slow_in(slow), .value_in(smp_val), .valid_out(valid), .data_out(adc_data));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Counted mid-cycle so that tasks resuming on the rising edge never race it
  always @(negedge clk_in)
  begin
    if (rec_trig === 1'b1)
      n_trig++;
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1)
    begin
      n_fail++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [PADDR_W-1:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask
  function automatic logic [PADDR_W-1:0] cha(input logic ch, input logic [1:0] r);
    return {CH_BLK, ch, r, 2'b00};
  endfunction
  function automatic logic [PADDR_W-1:0] mem(input logic [1:0] s, input logic [7:0] i);
    return {1'b1, s, i, 2'b00};
  endfunction
  task automatic cfg(input logic ch, input logic [31:0] c, input logic [31:0] l,
    input logic [31:0] h);
    wr(cha(ch, CH_REG_CFG), c);
    wr(cha(ch, CH_REG_LVL), l);
    wr(cha(ch, CH_REG_HYS), h);
  endtask
  task automatic sync();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (valid !== 1'b1 && n < 300);
    if (valid !== 1'b1)
    begin
      n_fail++;
      results();
    end
  endtask
  task automatic smp(input logic [SMP_W-1:0] v0, input logic [SMP_W-1:0] v1);
    smp_val <= {v1, v0};
    sync();
    tick(3);
  endtask
  task automatic start(input logic [31:0] ctrl, input logic [31:0] dly);
    wr(ADR_CTRL, ctrl);
    wr(ADR_DELAY, dly);
    sync();
    wr(ADR_CMD, 32'h0000_0001);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(ADR_STATUS, q);
    chk(q, 32'h0000_0000);
    apb(1'b0, cha(1'b0, 2'h3), 32'h0000_0000, q, e);
    chk(32'(e), 32'h0000_0001);
    chk(q, 32'h0000_0000);
    wr(ADR_DELAY, 32'hFFFF_0005);
    rd(ADR_DELAY, q);
    chk(q, 32'h0000_0005);
  endtask
  task automatic t_basic();
    logic [31:0] q;
    int t0;
    cfg(1'b0, 32'h0000_0001, 32'h0000_0064, 32'h0000_000A);
    cfg(1'b1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    start(32'h0000_0000, 32'h0000_0000);
    t0 = n_trig;
    smp(16'h0032, 16'h0000);
    smp(16'h0064, 16'h0000);
    chk(n_trig, t0);
    smp(16'h0065, 16'h0000);
    chk(n_trig, t0 + 1);
    smp(16'h0070, 16'h0000);
    rd(ADR_STATUS, q);
    chk(q, 32'h0000_0313);
    rd(ADR_TRIG_IDX, q);
    chk(q, 32'h0000_0002);
    rd(mem(2'h0, 8'h02), q);
    chk(q, 32'h0000_0065);
    chk(32'(done), 32'h0000_0001);
  endtask
  task automatic t_neg();
    logic [31:0] q;
    int t0;
    cfg(1'b0, 32'h0000_0000, 32'h0000_0064, 32'h0000_000A);
    cfg(1'b1, 32'h0000_0005, 32'h0000_FF9C, 32'h0000_000A);
    slow <= 1'b1;
    start(32'h0000_0010, 32'h0000_0003);
    t0 = n_trig;
    smp(16'h0000, 16'hFF38);
    smp(16'h00C8, 16'hFF38);
    smp(16'h00C8, 16'hFFA1);
    smp(16'h00C8, 16'hFF9B);
    chk(n_trig, t0);
    smp(16'h00C8, 16'h0000);
    smp(16'h00C8, 16'hFF9B);
    chk(n_trig, t0 + 1);
    smp(16'h00C8, 16'h0000);
    smp(16'h00C8, 16'h0000);
    rd(ADR_STATUS, q);
    chk(q, 32'h0001_0812);
    smp(16'h00C8, 16'h0000);
    rd(ADR_STATUS, q);
    chk(q, 32'h0001_0913);
    rd(mem(2'h1, 8'h05), q);
    chk(q, 32'hFF9B_00C8);
    slow <= 1'b0;
  endtask
  task automatic t_wrap();
    logic [31:0] q;
    int t0;
    cfg(1'b1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    start(32'h0000_0021, 32'h0000_0000);
    smp(16'h0005, 16'h0000);
    rd(ADR_STATUS, q);
    chk(q, 32'h0002_0001);
    wr(ADR_CTRL, 32'h0000_0020);
    for (int i = 0; i < 257; i++)
      smp(16'(i), 16'h0000);
    rd(ADR_STATUS, q);
    chk(q, 32'h0002_0101);
    rd(mem(2'h2, 8'h00), q);
    chk(q, 32'h0000_0100);
    rd(mem(2'h2, 8'h01), q);
    chk(q, 32'h0000_0001);
    t0 = n_trig;
    // External edge counts only once enabled
    for (int k = 0; k < 2; k++)
    begin
      wr(ADR_CTRL, k ? 32'h0000_0022 : 32'h0000_0020);
      ext_trig <= 1'b1;
      tick(2);
      ext_trig <= 1'b0;
      tick(8);
      chk(n_trig, t0 + k);
    end
    wr(ADR_CMD, 32'h0000_0004);
    tick(4);
    chk(n_trig, t0 + 1);
    rd(ADR_TRIG_IDX, q);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_dual();
    logic [31:0] q;
    int t0;
    cfg(1'b0, 32'h0000_0002, 32'hFF9C_0064, 32'h000A_000A);
    start(32'h0000_0000, 32'h0000_0000);
    t0 = n_trig;
    smp(16'h0000, 16'h0000);
    smp(16'hFF9B, 16'h0000);
    chk(n_trig, t0 + 1);
    rd(ADR_TRIG_IDX, q);
    chk(q, 32'h0000_0001);
    start(32'h0000_0000, 32'h0000_0000);
    wr(ADR_CMD, 32'h0000_0004);
    tick(4);
    chk(n_trig, t0 + 2);
  endtask
  // Delay beyond the segment: trigger sample is overwritten, then stop aborts
  task automatic t_post();
    logic [31:0] q;
    cfg(1'b0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    start(32'h0000_0030, 32'h0000_0101);
    smp(16'h0001, 16'h0000);
    wr(ADR_CMD, 32'h0000_0004);
    rd(ADR_TRIG_IDX, q);
    chk(q, 32'h0000_0000);
    for (int i = 0; i < 256; i++)
      smp(16'(i + 2), 16'h0000);
    rd(ADR_STATUS, q);
    chk(q, 32'h0003_0112);
    rd(mem(2'h3, 8'h00), q);
    chk(q, 32'h0000_0101);
    wr(ADR_CMD, 32'h0000_0002);
    rd(ADR_STATUS, q);
    chk(q, 32'h0003_0110);
    chk(32'(done), 32'h0000_0000);
  endtask
  initial
  begin
    rst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    smp_val = '0;
    slow = 1'b0;
    ext_trig = 1'b0;
    n_fail = 0;
    comparisons = 0;
    n_trig = 0;
    tick(3);
    rst_n_in <= 1'b1;
    tick(1);
    t_regs();
    t_basic();
    t_neg();
    t_wrap();
    t_dual();
    t_post();
    results();
  end
endmodule // trigger_sweep_capture_tb
